/* File: user_nvm_store.sv */
`timescale 1ns/1ps
`default_nettype none
`include "user_nvm_regs.svh"
module user_nvm_store (
    input wire logic clock,
    input wire logic reset,
    input wire logic [6:0] rd_addr,
    input wire logic rd_en,
    output logic [7:0] rd_data,
    output logic rd_valid,
    input wire logic prog_req,
    input wire logic [1:0] prog_op,
    input wire logic [2:0] prog_bank,
    input wire logic [127:0] prog_data,
    input wire logic prog_decrypt,
    input wire logic [127:0] prog_key,
    output logic prog_done,
    output logic [127:0] prog_rdata
);
    function automatic logic [2:0] bank_of(input logic [6:0] a);
        bank_of = a[`NVM_BANK_MSB:`NVM_BANK_LSB];
    endfunction
    function automatic logic [3:0] byte_of(input logic [6:0] a);
        byte_of = a[`NVM_BYTE_MSB:`NVM_BYTE_LSB];
    endfunction

    // picks one byte lane out of a bank word
    function automatic logic [7:0] lane_of(
        input logic [127:0] w,
        input logic [3:0] idx
    );
        logic [7:0] r;
        r = 8'h00;
        for (int i = 0; i < `NVM_BYTES_PER_BANK; i++) begin
            if (idx == 4'(i)) begin
                r = w[i*8 +: 8];
            end
        end
        lane_of = r;
    endfunction

    // operations the programming side may request
    function automatic logic op_valid(input logic [1:0] o);
        op_valid = (o == `NVM_OP_ERASE) || (o == `NVM_OP_WRITE) || (o == `NVM_OP_READ);
    endfunction

    // non-volatile: the array has a clock but no reset
    logic [127:0] mem_ff [0:`NVM_BANKS-1];
    logic [127:0] load_data;
    logic [127:0] data_ff;
    logic [1:0] op_ff;
    logic [2:0] bank_ff;
    user_nvm_pkg::prog_state_e state_ff;
    user_nvm_pkg::prog_state_e nxt_state;
    logic done_ff;
    logic [127:0] prog_rdata_ff;
    logic [7:0] rd_data_ff;
    logic rd_valid_ff;
    logic accept;
    logic erase_stb;
    logic write_stb;
    logic read_stb;
    logic store_we;
    logic op_finish;
    logic [7:0] sel_byte;

    user_nvm_key_xor u_dec (
        .enable(prog_decrypt),
        .key(prog_key),
        .bank(prog_bank),
        .data_in(prog_data),
        .data_out(load_data)
    );

    assign accept = (state_ff == user_nvm_pkg::prog_idle) && prog_req && !done_ff
        && op_valid(prog_op);
    assign erase_stb = (state_ff == user_nvm_pkg::prog_erase);
    assign write_stb = (state_ff == user_nvm_pkg::prog_write);
    assign read_stb = (state_ff == user_nvm_pkg::prog_read);
    assign store_we = erase_stb || write_stb;
    // a write runs as erase then program; a plain erase ends after its step
    assign op_finish = (erase_stb && (op_ff == `NVM_OP_ERASE)) || write_stb || read_stb;

    // request latch: operation, bank and optionally decrypted data
    always_ff @(posedge clock or posedge reset) begin
        if (reset) begin
            op_ff <= `NVM_OP_IDLE;
            bank_ff <= 3'h0;
            data_ff <= 128'h0;
        end else if (accept) begin
            op_ff <= prog_op;
            bank_ff <= prog_bank;
            data_ff <= load_data;
        end
    end

    always_ff @(posedge clock or posedge reset) begin
        if (reset) begin
            state_ff <= user_nvm_pkg::prog_idle;
        end else begin
            state_ff <= nxt_state;
        end
    end

    always_comb begin
        nxt_state = state_ff;
        case (state_ff)
            user_nvm_pkg::prog_idle: begin
                if (accept) begin
                    if (prog_op == `NVM_OP_READ) begin
                        nxt_state = user_nvm_pkg::prog_read;
                    end else begin
                        nxt_state = user_nvm_pkg::prog_erase;
                    end
                end
            end
            user_nvm_pkg::prog_erase: begin
                if (op_ff == `NVM_OP_WRITE) begin
                    nxt_state = user_nvm_pkg::prog_write;
                end else begin
                    nxt_state = user_nvm_pkg::prog_idle;
                end
            end
            user_nvm_pkg::prog_write: begin
                nxt_state = user_nvm_pkg::prog_idle;
            end
            user_nvm_pkg::prog_read: begin
                nxt_state = user_nvm_pkg::prog_idle;
            end
            default: begin
                nxt_state = user_nvm_pkg::prog_idle;
            end
        endcase
    end

    // only programming-port strobes reach the array; core reads never write
    always_ff @(posedge clock) begin
        if (erase_stb) begin
            mem_ff[bank_ff] <= {`NVM_BYTES_PER_BANK{`NVM_ERASED_BYTE}};
        end else if (write_stb) begin
            // programming can only clear bits of an erased bank
            mem_ff[bank_ff] <= mem_ff[bank_ff] & data_ff;
        end
    end

    // done stands until the requester lets go; completion wins a clash
    always_ff @(posedge clock or posedge reset) begin
        if (reset) begin
            done_ff <= 1'b0;
        end else if (op_finish) begin
            done_ff <= 1'b1;
        end else if (!prog_req) begin
            done_ff <= 1'b0;
        end
    end

    always_ff @(posedge clock or posedge reset) begin
        if (reset) begin
            prog_rdata_ff <= 128'h0;
        end else if (read_stb) begin
            prog_rdata_ff <= mem_ff[bank_ff];
        end
    end

    // core read: address taken on the edge, byte out after it and held
    always_ff @(posedge clock or posedge reset) begin
        if (reset) begin
            rd_data_ff <= 8'h00;
        end else if (rd_en) begin
            rd_data_ff <= lane_of(mem_ff[bank_of(rd_addr)], byte_of(rd_addr));
        end
    end

    always_ff @(posedge clock or posedge reset) begin
        if (reset) begin
            rd_valid_ff <= 1'b0;
        end else begin
            rd_valid_ff <= rd_en;
        end
    end

    assign rd_data = rd_data_ff;
    assign rd_valid = rd_valid_ff;
    assign prog_done = done_ff;
    assign prog_rdata = prog_rdata_ff;

    // checker byte pick by shift, independent of the lane function
    assign sel_byte = 8'(mem_ff[rd_addr[`NVM_BANK_MSB:`NVM_BANK_LSB]]
        >> {rd_addr[`NVM_BYTE_MSB:`NVM_BYTE_LSB], 3'h0});

    a_read_valid_next: assert property (@(posedge clock) disable iff (reset)
        rd_en |=> rd_valid)
        else $error("read valid missing after a core read");

    a_read_byte_lane: assert property (@(posedge clock) disable iff (reset)
        rd_en |=> (rd_data == $past(sel_byte)))
        else $error("read byte differs from the addressed lane");

    a_read_data_hold: assert property (@(posedge clock) disable iff (reset)
        !rd_en |=> $stable(rd_data))
        else $error("read data moved without a read");

    a_valid_follows_read: assert property (@(posedge clock) disable iff (reset)
        rd_valid |-> $past(rd_en))
        else $error("read valid without a read request");

    a_store_prog_only: assert property (@(posedge clock) disable iff (reset)
        store_we |-> prog_req)
        else $error("store written without a programming request");

    a_done_holds: assert property (@(posedge clock) disable iff (reset)
        (prog_done && prog_req) |=> prog_done)
        else $error("done dropped while the request stands");

    a_erase_done: assert property (@(posedge clock) disable iff (reset)
        (erase_stb && (op_ff == `NVM_OP_ERASE)) |=> prog_done)
        else $error("erase finished without done");

    a_write_after_erase: assert property (@(posedge clock) disable iff (reset)
        write_stb |-> $past(erase_stb))
        else $error("bank programmed without a preceding erase");

    c_core_read: cover property (@(posedge clock) disable iff (reset)
        rd_en ##1 rd_valid);
    c_bank_erase: cover property (@(posedge clock) disable iff (reset)
        erase_stb && (op_ff == `NVM_OP_ERASE));
    c_bank_write: cover property (@(posedge clock) disable iff (reset)
        write_stb);
    c_bank_readback: cover property (@(posedge clock) disable iff (reset)
        read_stb);
endmodule
`default_nettype wire

/* File: user_nvm_regs.svh */
`ifndef USER_NVM_REGS_SVH
`define USER_NVM_REGS_SVH
`define NVM_BANKS 8
`define NVM_BANK_BITS 128
`define NVM_BYTES_PER_BANK 16
`define NVM_ADDR_W 7
`define NVM_BANK_MSB 6
`define NVM_BANK_LSB 4
`define NVM_BYTE_MSB 3
`define NVM_BYTE_LSB 0
`define NVM_ERASED_BYTE 8'hff
`define NVM_OP_IDLE 2'h0
`define NVM_OP_ERASE 2'h1
`define NVM_OP_WRITE 2'h2
`define NVM_OP_READ 2'h3
`endif

/* File: user_nvm_pkg.sv */
package user_nvm_pkg;
    typedef logic [6:0] nvm_addr_t;
    typedef logic [7:0] nvm_byte_t;
    typedef logic [127:0] nvm_bank_t;
    typedef enum logic [1:0] {
        prog_idle = 2'b00,
        prog_erase = 2'b01,
        prog_write = 2'b11,
        prog_read = 2'b10
    } prog_state_e;
endpackage

/* File: user_nvm_key_xor.sv */
`timescale 1ns/1ps
`default_nettype none
`include "user_nvm_regs.svh"
// optional decryption of a loaded bank: keystream xor per bank
module user_nvm_key_xor (
    input wire logic enable,
    input wire logic [127:0] key,
    input wire logic [2:0] bank,
    input wire logic [127:0] data_in,
    output logic [127:0] data_out
);
    logic [127:0] stream;
    assign stream = {key[119:0], key[127:120] ^ {5'h00, bank}};
    assign data_out = enable ? (data_in ^ stream) : data_in;
endmodule
`default_nettype wire

/* File: nvm_core_reader.sv */
`timescale 1ns/1ps
`default_nettype none
module nvm_core_reader (
    input wire logic req,
    input wire logic [6:0] addr,
    output logic rd_en,
    output logic [6:0] rd_addr
);
    // idle address inverted
    assign rd_en = req;
    assign rd_addr = req ? addr : ~addr;
endmodule
`default_nettype wire

/* File: user_nvm_byte_read_port_test.sv */
`timescale 1ns/1ps
`default_nettype none
`define CHK(n,e,s) begin cmp_count++; if ((s)!==(e)) begin miscompares++; \
    $display("[FAIL] %s exp %h got %h", n, e, s); end end
module user_nvm_byte_read_port_test;
    logic clock = 0, reset = 1, req = 0, preq = 0, re, pd, rv;
    logic [1:0] op = 2'h0;
    logic [2:0] pb = 3'h0;
    logic [6:0] a = 7'h00, ra;
    logic [7:0] rd;
    logic [127:0] d = 128'h0f1e2d3c4b5a69788796a5b4c3d2e1f0;
    logic [127:0] d2 = 128'h00112233445566778899aabbccddeeff;
    logic [127:0] pdat = 128'h0, pr;
    int miscompares = 0, cmp_count = 0;
    initial forever #12.5 clock = ~clock;
    nvm_core_reader core(.req(req), .addr(a), .rd_en(re), .rd_addr(ra));
    user_nvm_store dut(.clock(clock), .reset(reset), .rd_addr(ra), .rd_en(re), .rd_data(rd),
        .rd_valid(rv), .prog_req(preq), .prog_op(op), .prog_bank(pb), .prog_data(pdat),
        .prog_decrypt(1'b0), .prog_key(128'h0), .prog_done(pd), .prog_rdata(pr));
    task summarize;
        if (miscompares == 0 && cmp_count > 0) $display("Regression OK");
        else $display("Regression broken");
        $finish;
    endtask
    task prog(input logic [1:0] o, input logic [2:0] b, input logic [127:0] v);
        int i;
        @(negedge clock) op = o;
        pb = b;
        pdat = v;
        preq = 1;
        for (i = 0; i < 999 && pd !== 1'b1; i++) @(negedge clock);
        `CHK("done", 1'b1, pd)
        if (pd !== 1'b1) summarize;
        else preq = 0;
    endtask
    task rd_byte(input logic [6:0] x, input logic [7:0] e);
        @(negedge clock) a = x;
        req = 1;
        @(negedge clock) req = 0;
        `CHK("valid", 1'b1, rv)
        `CHK("byte", e, rd)
        @(negedge clock) `CHK("pulse", 1'b0, rv)
        repeat (3) @(negedge clock);
        `CHK("held", e, rd)
    endtask
    task readback(input logic [2:0] b, input logic [127:0] e);
        prog(2'h3, b, 128'h0);
        `CHK("readback", e, pr)
    endtask
    initial begin
        repeat (20) @(negedge clock);
        reset = 0;
        prog(2'h2, 3'h5, d);
        rd_byte(7'h53, d[31:24]);
        prog(2'h2, 3'h2, d2);
        rd_byte(7'h2a, d2[87:80]);
        rd_byte(7'h5f, d[127:120]);
        readback(3'h5, d);
        @(negedge clock) reset = 1;
        repeat (3) @(negedge clock);
        reset = 0;
        `CHK("reset valid", 1'b0, rv)
        rd_byte(7'h21, d2[15:8]);
        prog(2'h1, 3'h5, d);
        rd_byte(7'h50, 8'hff);
        readback(3'h2, d2);
        summarize;
    end
endmodule
`default_nettype wire
